// file: core/diag_mem.sv
// small parameter memory with registered read data
`timescale 1ns/10ps
module diag_mem #(
  parameter int unsigned WORDS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  diag_if.mem      bus
);
  logic [$bits(bus.wr_data)-1:0] mem_q [WORDS];
  logic [$bits(bus.wr_data)-1:0] rd_q;

  always_ff @(posedge sys_clk) begin
    if (bus.wr_en) begin
      mem_q[bus.addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_q[bus.addr];
    end
  end

  assign bus.rd_data = rd_q;
endmodule

// file: core/safety_switch_output_logic.sv
// output, plausibility, indicator and diagnostic link logic of the safety switch
`timescale 1ns/10ps
module safety_switch_output_logic #(
  parameter int unsigned FAST_HALF = safety_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_HALF = safety_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned STARTUP   = safety_pkg::STARTUP_CYCLES,
  parameter int unsigned DETECT    = safety_pkg::DETECT_CYCLES,
  parameter int unsigned BIT_LEN   = safety_pkg::BIT_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         actuator_present,
  input  wire logic                         safety_in_ch1,
  input  wire logic                         safety_in_ch2,
  input  wire logic                         diag_in,
  input  wire logic [safety_pkg::NODE_W-1:0] node_id,
  input  wire logic [15:0]                  serial_number,
  input  wire logic [7:0]                   teach_remaining,
  input  wire logic [7:0]                   actuator_name,
  output logic                              safety_out_ch1,
  output logic                              safety_out_ch2,
  output logic                              status_diag_out,
  output logic                              device_indicator_green,
  output logic                              device_indicator_red,
  output logic                              input_indicator_yellow
);
  localparam int unsigned BW = $clog2(SLOW_HALF + STARTUP + DETECT + BIT_LEN + 2);
  localparam int unsigned DW = safety_pkg::DATA_W;

  function automatic logic [BW-1:0] cnt(input int unsigned v);
    return BW'(v);
  endfunction

  // input synchronisers
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {actuator_present, safety_in_ch1, safety_in_ch2, diag_in};
      sync_q <= meta_q;
    end
  end
  wire present = sync_q[3];
  wire in1     = sync_q[2];
  wire in2     = sync_q[1];
  wire dline   = sync_q[0];

  // ready for operation after start-up delay
  logic [BW-1:0] st_cnt_q;
  logic          ready_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      st_cnt_q <= st_cnt_q + cnt(1);
      ready_q  <= (st_cnt_q == cnt(STARTUP - 1));
    end
  end

  // plausibility monitoring
  safety_pkg::plaus_state_type pl_q;
  safety_pkg::plaus_state_type pl_d;
  logic in1_q;
  logic in2_q;
  logic which_q;
  logic which_d;
  wire fall1    = in1_q & ~in1;
  wire fall2    = in2_q & ~in2;
  wire rise1    = ~in1_q & in1;
  wire rise2    = ~in2_q & in2;
  wire both_low = ~in1 & ~in2;
  wire back_up  = which_q ? (rise2 & in1 & in1_q) : (rise1 & in2 & in2_q);

  always_comb begin
    pl_d    = pl_q;
    which_d = which_q;
    unique case (pl_q)
      safety_pkg::PL_NORMAL: begin
        if (fall1 && in2 && in2_q) begin
          pl_d    = safety_pkg::PL_UNEQUAL;
          which_d = 1'b0;
        end else if (fall2 && in1 && in1_q) begin
          pl_d    = safety_pkg::PL_UNEQUAL;
          which_d = 1'b1;
        end
      end
      safety_pkg::PL_UNEQUAL: begin
        if (both_low) begin
          pl_d = safety_pkg::PL_NORMAL;
        end else if (back_up) begin
          pl_d = safety_pkg::PL_LOCK;
        end
      end
      safety_pkg::PL_LOCK: begin
        if (both_low) begin
          pl_d = safety_pkg::PL_NORMAL;
        end
      end
      default: pl_d = safety_pkg::PL_LOCK;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pl_q    <= safety_pkg::PL_NORMAL;
      which_q <= 1'b0;
      in1_q   <= 1'b0;
      in2_q   <= 1'b0;
    end else begin
      pl_q    <= pl_d;
      which_q <= which_d;
      in1_q   <= in1;
      in2_q   <= in2;
    end
  end
  wire locked  = (pl_q == safety_pkg::PL_LOCK);
  wire unequal = (pl_q == safety_pkg::PL_UNEQUAL);

  // safety outputs, independent of the link
  // no output pulse in the cycle that enters the lock
  wire to_lock = unequal & back_up;
  wire pass  = present & ready_q & ~locked & ~to_lock;
  wire out1_d = pass & in1;
  wire out2_d = pass & in2;

  // blink dividers
  logic [BW-1:0] fast_cnt_q;
  logic [BW-1:0] slow_cnt_q;
  logic          fast_tog_q;
  logic          slow_tog_q;
  wire fast_en = (fast_cnt_q == cnt(FAST_HALF - 1));
  wire slow_en = (slow_cnt_q == cnt(SLOW_HALF - 1));
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_cnt_q <= '0;
      slow_cnt_q <= '0;
      fast_tog_q <= 1'b0;
      slow_tog_q <= 1'b0;
    end else begin
      fast_cnt_q <= fast_en ? '0 : fast_cnt_q + cnt(1);
      slow_cnt_q <= slow_en ? '0 : slow_cnt_q + cnt(1);
      fast_tog_q <= fast_tog_q ^ fast_en;
      slow_tog_q <= slow_tog_q ^ slow_en;
    end
  end
  wire fault    = unequal | locked;
  wire green_d  = ready_q & ~fault;
  wire red_d    = ready_q & fault & slow_tog_q;
  wire yellow_d = unequal ? fast_tog_q : (locked ? slow_tog_q : (in1 & in2));

  // module detection, re-done after each reset
  logic [BW-1:0] det_cnt_q;
  logic          link_on_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      det_cnt_q <= '0;
      link_on_q <= 1'b0;
    end else if (!link_on_q) begin
      det_cnt_q <= dline ? det_cnt_q + cnt(1) : '0;
      link_on_q <= dline && (det_cnt_q == cnt(DETECT - 1));
    end
  end

  // link receiver, 8N1
  logic          dline_q;
  logic          rx_busy_q;
  logic [BW-1:0] rx_cnt_q;
  logic [3:0]    rx_idx_q;
  logic [DW-1:0] rx_sh_q;
  logic          rx_done_q;
  wire rx_tick = rx_busy_q && (rx_cnt_q == '0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dline_q   <= 1'b1;
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= '0;
      rx_done_q <= 1'b0;
    end else begin
      dline_q   <= dline;
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (link_on_q && dline_q && !dline) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= cnt(BIT_LEN / 2);
          rx_idx_q  <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_cnt_q <= cnt(BIT_LEN - 1);
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && dline) begin
          rx_busy_q <= 1'b0;
        end else if (rx_idx_q == 4'(safety_pkg::BIT_LAST)) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= dline;
        end else if (rx_idx_q != 4'h0) begin
          rx_sh_q <= {dline, rx_sh_q[DW-1:1]};
        end
      end else begin
        rx_cnt_q <= rx_cnt_q - cnt(1);
      end
    end
  end

  // command decode and parameter memory
  diag_if #(.AW(safety_pkg::ADDR_W), .DW(DW)) mem_bus ();
  logic [2:0]                    init_q;
  logic                          pend_q;
  logic [safety_pkg::ADDR_W-1:0] cmd_addr_q;
  logic                          tx_busy_q;
  wire [1:0] op       = rx_sh_q[safety_pkg::CMD_OP_HI:safety_pkg::CMD_OP_LO];
  wire       for_me   = rx_done_q && !tx_busy_q && !pend_q
                        && rx_sh_q[safety_pkg::CMD_NODE_HI:safety_pkg::CMD_NODE_LO] == node_id;
  wire       do_param = for_me && (op == safety_pkg::OP_READ_PARAM);
  wire       do_stat  = for_me && (op == safety_pkg::OP_READ_STATUS);
  wire       do_act   = for_me && (op == safety_pkg::OP_ACTION_NAME);
  wire       init_on  = ~init_q[2];
  wire [safety_pkg::ADDR_W-1:0] init_addr = init_q[safety_pkg::ADDR_W-1:0];
  wire [DW-1:0] init_word = (init_addr == safety_pkg::PAR_SERIAL_LO) ? serial_number[7:0] :
                            (init_addr == safety_pkg::PAR_SERIAL_HI) ? serial_number[15:8] :
                            (init_addr == safety_pkg::PAR_TEACH)     ? teach_remaining :
                                                                       actuator_name;
  // status byte reports switching and chain continuity
  wire [DW-1:0] status_byte = {present, in1, in2, out1_d, out2_d, locked, unequal, ready_q};

  assign mem_bus.addr    = init_on ? init_addr :
                           (do_act ? safety_pkg::PAR_NAME :
                           (do_param ? rx_sh_q[safety_pkg::ADDR_W-1:0] : cmd_addr_q));
  assign mem_bus.wr_en   = init_on | do_act;
  assign mem_bus.wr_data = init_on ? init_word : actuator_name;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_q     <= 3'h0;
      pend_q     <= 1'b0;
      cmd_addr_q <= '0;
    end else begin
      if (init_on) begin
        init_q <= init_q + 3'h1;
      end
      pend_q <= do_param;
      if (do_param) begin
        cmd_addr_q <= rx_sh_q[safety_pkg::ADDR_W-1:0];
      end
    end
  end

  diag_mem #(.WORDS(safety_pkg::MEM_WORDS)) u_mem (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (mem_bus)
  );

  // link transmitter
  logic [safety_pkg::FRAME_W-1:0] tx_sh_q;
  logic [BW-1:0]                  tx_cnt_q;
  logic [3:0]                     tx_left_q;
  wire          tx_load = pend_q | do_stat | do_act;
  wire [DW-1:0] tx_byte = pend_q ? mem_bus.rd_data : (do_act ? actuator_name : status_byte);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= '1;
      tx_cnt_q  <= '0;
      tx_left_q <= 4'h0;
    end else if (!tx_busy_q) begin
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, tx_byte, 1'b0};
        tx_cnt_q  <= cnt(BIT_LEN - 1);
        tx_left_q <= 4'(safety_pkg::BIT_LAST);
      end
    end else if (tx_cnt_q == '0) begin
      tx_cnt_q <= cnt(BIT_LEN - 1);
      tx_sh_q  <= {1'b1, tx_sh_q[safety_pkg::FRAME_W-1:1]};
      if (tx_left_q == 4'h0) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_left_q <= tx_left_q - 4'h1;
      end
    end else begin
      tx_cnt_q <= tx_cnt_q - cnt(1);
    end
  end
  wire tx_line  = tx_busy_q ? tx_sh_q[0] : 1'b1;
  wire status_d = link_on_q ? tx_line : present;

  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      safety_out_ch1         <= 1'b0;
      safety_out_ch2         <= 1'b0;
      status_diag_out        <= 1'b0;
      device_indicator_green <= 1'b0;
      device_indicator_red   <= 1'b0;
      input_indicator_yellow <= 1'b0;
    end else begin
      safety_out_ch1         <= out1_d;
      safety_out_ch2         <= out2_d;
      status_diag_out        <= status_d;
      device_indicator_green <= green_d;
      device_indicator_red   <= red_d;
      input_indicator_yellow <= yellow_d;
    end
  end
endmodule

// file: pkg/diag_if.sv
// carrier between link control and parameter memory
`timescale 1ns/10ps
interface diag_if #(
  parameter int unsigned AW = 2,
  parameter int unsigned DW = 8
);
  logic [AW-1:0] addr;
  logic          wr_en;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] rd_data;

  modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
  modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// file: pkg/safety_pkg.sv
// constants, types and timing for the safety switch output logic
// Overview of operation
// - no actuator: both safety outputs low
// - actuator present: each output follows its input
// - no link: status output shows actuator presence
// - mapping only when ready; green indicator
// - one input falls: unequal state, blink
// - same input returns high: partial lock
// - rise honoured only after both low
// - link enabled only when module detected
// - link mode: status output carries data
// - chain of up to 16 subscribers
// - link rebuilt after every power-up
// - answer reads of configuration parameters
// - report switching and chain status
// - execute action requests, return actuator name
// - link never alters safety outputs
package safety_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned FAST_BLINK_MS = 100;
  localparam int unsigned SLOW_BLINK_MS = 500;
  localparam int unsigned STARTUP_MS    = 10;
  localparam int unsigned DETECT_US     = 100;
  localparam int unsigned LINK_BAUD     = 19200;

  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / 1000 * FAST_BLINK_MS / 2;
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / 1000 * SLOW_BLINK_MS / 2;
  localparam int unsigned STARTUP_CYCLES   = CLK_HZ / 1000 * STARTUP_MS;
  localparam int unsigned DETECT_CYCLES    = CLK_HZ / 1_000_000 * DETECT_US;
  localparam int unsigned BIT_CYCLES       = CLK_HZ / LINK_BAUD;

  localparam int unsigned MAX_NODES = 16;
  localparam int unsigned NODE_W    = $clog2(MAX_NODES);
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MEM_WORDS = 4;
  localparam int unsigned ADDR_W    = 2;
  localparam int unsigned FRAME_W   = 10;

  localparam logic [1:0] OP_READ_PARAM  = 2'h0;
  localparam logic [1:0] OP_READ_STATUS = 2'h1;
  localparam logic [1:0] OP_ACTION_NAME = 2'h2;

  localparam logic [ADDR_W-1:0] PAR_SERIAL_LO = 2'h0;
  localparam logic [ADDR_W-1:0] PAR_SERIAL_HI = 2'h1;
  localparam logic [ADDR_W-1:0] PAR_TEACH     = 2'h2;
  localparam logic [ADDR_W-1:0] PAR_NAME      = 2'h3;

  localparam int unsigned CMD_OP_HI   = 7;
  localparam int unsigned CMD_OP_LO   = 6;
  localparam int unsigned CMD_NODE_HI = 5;
  localparam int unsigned CMD_NODE_LO = 2;
  localparam int unsigned BIT_LAST    = 9;

  typedef enum logic [2:0] {
    PL_NORMAL  = 3'b001,
    PL_UNEQUAL = 3'b010,
    PL_LOCK    = 3'b100
  } plaus_state_type;
endpackage

// file: test/chain_partner.sv
// upstream chain partner: safety inputs and the diagnostic line
`timescale 1ns/10ps
module chain_partner #(
  parameter int unsigned BIT_LEN = 8
) (
  input  wire logic sys_clk,
  input  wire logic status_diag_out,
  output logic      safety_in_ch1,
  output logic      safety_in_ch2,
  output logic      diag_in
);
  initial {safety_in_ch1, safety_in_ch2, diag_in} = 3'h0;
  task automatic drive(input logic a, input logic b);
    @(posedge sys_clk) #1;
    safety_in_ch1 = a;
    safety_in_ch2 = b;
  endtask
  // line idles high once a module is attached
  task automatic attach();
    @(posedge sys_clk) #1;
    diag_in = 1'h1;
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk) #1;
      diag_in = frame[i];
      repeat (BIT_LEN - 1) @(posedge sys_clk);
    end
  endtask
  task automatic get_byte(output logic [7:0] b, output logic ok);
    ok = 1'h0;
    b = 8'h00;
    for (int i = 0; i < 250 && !ok; i++) begin
      @(posedge sys_clk) #1;
      ok = !status_diag_out;
    end
    for (int i = 0; i < 8 && ok; i++) begin
      repeat (i == 0 ? BIT_LEN * 3 / 2 : BIT_LEN) @(posedge sys_clk);
      #1 b[i] = status_diag_out;
    end
  endtask
endmodule

// file: test/safety_switch_output_logic_properties.sv
// concurrent checks on the ports of the safety switch output logic
`timescale 1ns/10ps
module safety_switch_output_logic_checker #(
  parameter int unsigned STARTUP = safety_pkg::STARTUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic actuator_present,
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  input wire logic diag_in,
  input wire logic safety_out_ch1,
  input wire logic safety_out_ch2,
  input wire logic status_diag_out,
  input wire logic device_indicator_green
);
  logic [31:0] since_q;
  logic [1:0]  high_q;
  logic        link_q;
  logic        ready;
  logic        early;
  assign ready = since_q > STARTUP + 4;
  assign early = since_q + 1 < STARTUP;
  // link taken as on sooner than the device would see it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      since_q <= 32'h0;
      high_q  <= 2'h0;
      link_q  <= 1'h0;
    end else begin
      since_q <= (since_q == 32'hFFFFFFFF) ? since_q : since_q + 32'h1;
      high_q  <= !diag_in ? 2'h0 : (high_q == 2'h3) ? high_q : high_q + 2'h1;
      link_q  <= link_q | (high_q == 2'h3);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence fall_ch1;
    (safety_in_ch1 && safety_in_ch2)[*2] ##1 (!safety_in_ch1 && safety_in_ch2)[*8];
  endsequence
  sequence back_ch1;
    (!safety_in_ch1 && safety_in_ch2 && !device_indicator_green && ready)[*8]
      ##1 (safety_in_ch1 && safety_in_ch2)[*6];
  endsequence
  sequence rise_ch1;
    (!safety_in_ch1 && safety_in_ch2 && !device_indicator_green && ready)[*8]
      ##1 (safety_in_ch1 && safety_in_ch2);
  endsequence
  sequence both_cleared;
    (!safety_in_ch1 && !safety_in_ch2)[*4]
      ##1 (safety_in_ch1 && safety_in_ch2 && actuator_present && ready)[*5];
  endsequence
  no_actuator_a: assert property (
    !$past(actuator_present, 3) |-> !safety_out_ch1 && !safety_out_ch2)
    else $error("output without actuator");
  follow_ch1_a: assert property (
    safety_out_ch1 |-> $past(safety_in_ch1, 3) && $past(actuator_present, 3))
    else $error("channel 1 high unasked");
  follow_ch2_a: assert property (
    safety_out_ch2 |-> $past(safety_in_ch2, 3) && $past(actuator_present, 3))
    else $error("channel 2 high unasked");
  status_level_a: assert property (
    since_q > 32'h4 && !link_q |-> status_diag_out == $past(actuator_present, 3))
    else $error("status not presence");
  startup_quiet_a: assert property (
    early |-> !device_indicator_green && !safety_out_ch1 && !safety_out_ch2)
    else $error("active before ready");
  unequal_flag_a: assert property (fall_ch1 |-> !device_indicator_green)
    else $error("unequal not shown");
  lock_hold_a: assert property (back_ch1 |-> !safety_out_ch1 && !safety_out_ch2)
    else $error("lock not held");
  lock_entry_a: assert property (rise_ch1 |-> (!safety_out_ch1)[*6])
    else $error("output pulse on lock entry");
  unlock_pass_a: assert property (
    both_cleared |-> safety_out_ch1 && safety_out_ch2)
    else $error("outputs blocked");
endmodule

bind safety_switch_output_logic safety_switch_output_logic_checker #(.STARTUP(STARTUP)) checker_i (
  .sys_clk(sys_clk), .rst(rst), .actuator_present(actuator_present),
  .safety_in_ch1(safety_in_ch1), .safety_in_ch2(safety_in_ch2), .diag_in(diag_in),
  .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2),
  .status_diag_out(status_diag_out), .device_indicator_green(device_indicator_green)
);

// file: test/safety_switch_output_logic_test.sv
// self-checking bench for the safety switch output logic
`timescale 1ns/10ps
module safety_switch_output_logic_test;
  logic       sys_clk, rst, present, in1, in2, diag, out1, out2, status, green, red, yellow;
  logic [7:0] name;
  int         n_errors, num_checks;
  localparam int unsigned FAST_HALF = 4;
  localparam int unsigned SLOW_HALF = 10;
  localparam int unsigned STARTUP   = 20;
  localparam int unsigned DETECT    = 8;
  localparam int unsigned BIT_LEN   = 8;
  logic [3:0]  node;
  logic [15:0] serial;
  logic [7:0]  teach;

  safety_switch_output_logic #(
    .FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF), .STARTUP(STARTUP), .DETECT(DETECT),
    .BIT_LEN(BIT_LEN)
  ) safety_switch_output_logic_i (
    .sys_clk(sys_clk), .rst(rst), .actuator_present(present), .safety_in_ch1(in1),
    .safety_in_ch2(in2), .diag_in(diag), .node_id(node), .serial_number(serial),
    .teach_remaining(teach), .actuator_name(name), .safety_out_ch1(out1),
    .safety_out_ch2(out2), .status_diag_out(status), .device_indicator_green(green),
    .device_indicator_red(red), .input_indicator_yellow(yellow)
  );
  chain_partner #(.BIT_LEN(BIT_LEN)) chain_partner_i (
    .sys_clk(sys_clk), .status_diag_out(status), .safety_in_ch1(in1),
    .safety_in_ch2(in2), .diag_in(diag)
  );
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic blinks(input int n, output int cy, output int cr);
    logic ly, lr;
    cy = 0;
    cr = 0;
    ly = yellow;
    lr = red;
    repeat (n) begin
      @(posedge sys_clk) #1;
      cy += int'(yellow !== ly);
      cr += int'(red !== lr);
      ly = yellow;
      lr = red;
    end
  endtask
  task automatic t_ready();
    cyc(10);
    check({green, out1, out2}, 3'h0);
    cyc(20);
    check({green, out1, out2}, 3'h7);
  endtask
  task automatic t_truth();
    logic [2:0] v;
    for (int k = 0; k < 8; k++) begin
      v = 3'(k);
      chain_partner_i.drive(1'h0, 1'h0);
      cyc(4);
      present = v[2];
      chain_partner_i.drive(v[1], v[0]);
      cyc(6);
      check({out1, out2, status}, {v[2] & v[1], v[2] & v[0], v[2]});
    end
    check(green, 1'h1);
  endtask
  task automatic t_plaus(input logic c2);
    int cy, cr;
    chain_partner_i.drive(1'h1, 1'h1);
    cyc(6);
    chain_partner_i.drive(c2, !c2);
    cyc(8);
    check({out1, out2, green}, {c2, !c2, 1'h0});
    blinks(16, cy, cr);
    check(cy >= 3 && cr > 0, 1'h1);
    chain_partner_i.drive(1'h1, 1'h1);
    cyc(8);
    check({out1, out2, green}, 3'h0);
    blinks(24, cy, cr);
    check(cy inside {[1:3]} && cr > 0, 1'h1);
    chain_partner_i.drive(1'h0, 1'h0);
    cyc(6);
    chain_partner_i.drive(1'h1, 1'h1);
    cyc(6);
    check({out1, out2, green}, 3'h7);
  endtask
  task automatic t_link();
    logic [7:0] cmd [8];
    logic [7:0] exp [8];
    logic [7:0] got;
    logic       ok;
    cmd = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h54, 8'h94, 8'h17, 8'h18};
    exp = '{8'hA5, 8'hC3, 8'h07, 8'h3C, 8'hF9, 8'h5E, 8'h5E, 8'h00};
    chain_partner_i.attach();
    cyc(30);
    for (int k = 0; k < 8; k++) begin
      name = (k > 4) ? 8'h5E : 8'h3C;
      cyc(12);
      fork
        chain_partner_i.send_byte(cmd[k]);
        chain_partner_i.get_byte(got, ok);
      join
      check({ok, got}, {k < 7, exp[k]});
    end
    check({out1, out2}, 2'h3);
  endtask
  // mid-run reset: link must be found again, actuator absent
  task automatic t_relink();
    logic [7:0] got;
    logic       ok;
    present = 1'h0;
    rst = 1'h1;
    cyc(2);
    rst = 1'h0;
    cyc(6);
    check(status, 1'h0);
    cyc(24);
    check(status, 1'h1);
    fork
      chain_partner_i.send_byte(8'h54);
      chain_partner_i.get_byte(got, ok);
    join
    check({ok, got}, 9'h161);
    check({out1, out2, green}, 3'h1);
  endtask
  initial begin
    n_errors = 0;
    num_checks = 0;
    rst = 1'h1;
    present = 1'h1;
    name = 8'h3C;
    node = 4'h5;
    serial = 16'hC3A5;
    teach = 8'h07;
    chain_partner_i.drive(1'h1, 1'h1);
    cyc(12);
    rst = 1'h0;
    t_ready();
    t_truth();
    t_plaus(1'h0);
    t_plaus(1'h1);
    t_link();
    t_relink();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
endmodule
